// ### hdl/supply_monitor.sv
// supply voltage monitor: threshold register, status flag, low-supply event
// Notes on behaviour
// [R1] flag follows comparator while monitor active
// [R2] flag is read-only bit 5
// [R3] event only on flag falling one to zero
// [R4] no event if flag never was one
// [R5] new threshold above supply gives no event
// [R6] inactive in power-on and sleep states
// [R7] bit 4 selects low or high range
// [R8] bits 3:0 select threshold code
// [R9] host reads flag after new threshold
// [R10] host masks event or lowers threshold
// [R11] mask register bit 7 gates event
// [R12] comparator synchronised before flag and edge
`timescale 1ns/100ps
`include "supply_monitor_defines.svh"
module supply_monitor
    import supply_monitor_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           rst_b,
    input  wire logic           comparator_above,
    input  wire trx_state_type  transceiver_state_field,
    input  wire logic           synth_lock_flag,
    input  wire reg_access_type reg_access,
    output threshold_cfg_type   threshold_cfg,
    output logic                comparator_enable,
    output logic [15:0]         threshold_mv,
    output logic [7:0]          reg_rdata,
    output logic                supply_low_interrupt
);
    threshold_cfg_type cfg_r;
    threshold_cfg_type cfg_nxt;
    logic              reserved_r;
    logic              reserved_nxt;
    logic [7:0]        irq_mask_r;
    logic [7:0]        irq_mask_nxt;
    logic              supply_above_threshold_r;
    logic              above_nxt;
    logic              supply_low_event;
    logic              comp_sync;
    logic              active;
    logic              active_r;
    logic              enable_nxt;
    logic [15:0]       mv_nxt;
    logic [7:0]        rdata_nxt;
    logic              irq_nxt;

    level_sync u_comp_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in (comparator_above),
        .sync_out (comp_sync)
    ); // R12

    function automatic logic [15:0] threshold_of(input threshold_cfg_type c);
        logic [15:0] code;
        code = {12'h000, c.threshold_code};
        if (c.high_range_select) begin
            threshold_of = 16'(`HIGH_RANGE_BASE_MV + code * `HIGH_RANGE_STEP_MV); // R7 R8
        end else begin
            threshold_of = 16'(`LOW_RANGE_BASE_MV + code * `LOW_RANGE_STEP_MV); // R7 R8
        end
    endfunction : threshold_of

    // one place for the address compare shared by writes and reads
    function automatic logic addressed(input reg_access_type r, input logic [5:0] a);
        addressed = (r.addr == a);
    endfunction : addressed

    assign active = (transceiver_state_field == TRX_ACTIVE); // R6

    always_comb begin
        cfg_nxt      = cfg_r;
        reserved_nxt = reserved_r;
        irq_mask_nxt = irq_mask_r;
        if (reg_access.wr_en && addressed(reg_access, `SUPPLY_MONITOR_ADDR)) begin
            cfg_nxt.high_range_select = reg_access.wdata[`HIGH_RANGE_BIT]; // R7
            cfg_nxt.threshold_code    = reg_access.wdata[`THRESHOLD_CODE_MSB:`THRESHOLD_CODE_LSB]; // R8
            reserved_nxt              = reg_access.wdata[`RESERVED_BIT];
        end
        if (reg_access.wr_en && addressed(reg_access, `IRQ_MASK_ADDR)) begin
            irq_mask_nxt = reg_access.wdata; // R11
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r      <= '{`HIGH_RANGE_RESET, `THRESHOLD_CODE_RESET};
            reserved_r <= `RESERVED_RESET;
            irq_mask_r <= `IRQ_MASK_RESET;
        end else begin
            cfg_r      <= cfg_nxt;
            reserved_r <= reserved_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    always_comb begin
        // flag holds while inactive; the active_r term keeps leaving sleep from faking a fall
        above_nxt        = active ? comp_sync : supply_above_threshold_r; // R1 R6
        supply_low_event = active && active_r && supply_above_threshold_r
                           && !comp_sync; // R3 R4 R5 R12
        irq_nxt    = supply_low_event && irq_mask_r[`SUPPLY_LOW_IRQ_BIT]; // R11
        enable_nxt = active; // R6
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            supply_above_threshold_r <= 1'b0;
            active_r                 <= 1'b0;
            comparator_enable        <= 1'b0;
            supply_low_interrupt     <= 1'b0;
        end else begin
            supply_above_threshold_r <= above_nxt;
            active_r                 <= active;
            comparator_enable        <= enable_nxt;
            supply_low_interrupt     <= irq_nxt;
        end
    end

    always_comb begin
        mv_nxt    = threshold_of(cfg_nxt);
        rdata_nxt = 8'h00;
        if (reg_access.rd_en && addressed(reg_access, `SUPPLY_MONITOR_ADDR)) begin
            rdata_nxt[`LOCK_FLAG_BIT]       = synth_lock_flag;
            rdata_nxt[`RESERVED_BIT]        = reserved_r;
            rdata_nxt[`ABOVE_THRESHOLD_BIT] = supply_above_threshold_r; // R2
            rdata_nxt[`HIGH_RANGE_BIT]      = cfg_r.high_range_select; // R7
            rdata_nxt[`THRESHOLD_CODE_MSB:`THRESHOLD_CODE_LSB] = cfg_r.threshold_code; // R8
        end else if (reg_access.rd_en && addressed(reg_access, `IRQ_MASK_ADDR)) begin
            rdata_nxt = irq_mask_r; // R11
        end
    end

    // threshold outputs load on the same edge as the stored setting; threshold_mv is zero until the first edge after reset release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            threshold_cfg <= '{`HIGH_RANGE_RESET, `THRESHOLD_CODE_RESET};
            threshold_mv  <= 16'h0000;
            reg_rdata     <= 8'h00;
        end else begin
            threshold_cfg <= cfg_nxt;
            threshold_mv  <= mv_nxt;
            reg_rdata     <= rdata_nxt;
        end
    end

    a_flag_follows: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
        active |=> supply_above_threshold_r == $past(comp_sync))
        else $error("flag did not follow comparator");

    a_flag_readback: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
        reg_access.rd_en && reg_access.addr == `SUPPLY_MONITOR_ADDR
        |=> reg_rdata[`ABOVE_THRESHOLD_BIT] == $past(supply_above_threshold_r))
        else $error("flag read back wrong");

    a_irq_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
        supply_low_interrupt |-> $past(supply_above_threshold_r) && !supply_above_threshold_r)
        else $error("interrupt without falling flag");

    a_no_irq_low: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
        !supply_above_threshold_r ##1 !supply_above_threshold_r
        |-> ##1 !supply_low_interrupt)
        else $error("interrupt on steady low flag");

    a_fall_raises: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
        supply_low_event && irq_mask_r[`SUPPLY_LOW_IRQ_BIT] |=> supply_low_interrupt)
        else $error("falling flag lost");

    a_sleep_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
        !active |=> !supply_low_interrupt && $stable(supply_above_threshold_r))
        else $error("monitor acted while inactive");

    a_mask_gates: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
        !irq_mask_r[`SUPPLY_LOW_IRQ_BIT] |=> !supply_low_interrupt)
        else $error("masked interrupt escaped");

    // the release edge still shows the reset value of the millivolt output
    a_threshold_map: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7 R8
        $past(rst_b) |-> threshold_mv == (threshold_cfg.high_range_select
            ? 16'(`HIGH_RANGE_BASE_MV + threshold_cfg.threshold_code * `HIGH_RANGE_STEP_MV)
            : 16'(`LOW_RANGE_BASE_MV + threshold_cfg.threshold_code * `LOW_RANGE_STEP_MV)))
        else $error("threshold value wrong");

    a_irq_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
        supply_low_interrupt |=> !supply_low_interrupt)
        else $error("interrupt longer than one cycle");

    a_enable_follows: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
        active |=> comparator_enable)
        else $error("comparator not enabled while active");

    a_enable_drops: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
        !active |=> !comparator_enable)
        else $error("comparator enabled while inactive");

    a_cfg_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7 R8
        reg_access.wr_en && reg_access.addr == `SUPPLY_MONITOR_ADDR
        |=> threshold_cfg == $past(reg_access.wdata[`HIGH_RANGE_BIT:`THRESHOLD_CODE_LSB]))
        else $error("threshold setting not stored");

    a_cfg_readback: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7 R8
        reg_access.rd_en && reg_access.addr == `SUPPLY_MONITOR_ADDR
        |=> reg_rdata[`HIGH_RANGE_BIT:`THRESHOLD_CODE_LSB] == $past(threshold_cfg))
        else $error("threshold setting read back wrong");

    a_new_threshold_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b) // R5
        reg_access.wr_en && !supply_above_threshold_r |=> !supply_low_interrupt)
        else $error("interrupt after threshold write on low flag");

    a_resume_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
        active && !active_r |=> !supply_low_interrupt)
        else $error("interrupt on leaving an idle state");

    a_mask_store: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
        reg_access.wr_en && reg_access.addr == `IRQ_MASK_ADDR
        |=> irq_mask_r == $past(reg_access.wdata))
        else $error("mask write not stored");

    a_mask_readback: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
        reg_access.rd_en && reg_access.addr == `IRQ_MASK_ADDR
        |=> reg_rdata == $past(irq_mask_r))
        else $error("mask read back wrong");

    // a comparator edge must not reach the flag on the very next clock edge
    a_sync_latency: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
        $rose(comparator_above) |=> !$rose(supply_above_threshold_r))
        else $error("comparator reached flag unsynchronised");
endmodule : supply_monitor

// ### hdl/supply_monitor_defines.svh
// constants for the supply voltage monitor
`ifndef SUPPLY_MONITOR_DEFINES_SVH
`define SUPPLY_MONITOR_DEFINES_SVH
`define SUPPLY_MONITOR_ADDR          6'h11
`define IRQ_MASK_ADDR                6'h0E
`define SUPPLY_LOW_IRQ_BIT           7
`define LOCK_FLAG_BIT                7
`define RESERVED_BIT                 6
`define ABOVE_THRESHOLD_BIT          5
`define HIGH_RANGE_BIT               4
`define THRESHOLD_CODE_MSB           3
`define THRESHOLD_CODE_LSB           0
`define THRESHOLD_CODE_RESET         4'h2
`define HIGH_RANGE_RESET             1'h0
`define RESERVED_RESET               1'h0
`define IRQ_MASK_RESET               8'h00
`define LOW_RANGE_BASE_MV            16'h06A4
`define LOW_RANGE_STEP_MV            16'h0032
`define HIGH_RANGE_BASE_MV           16'h09F6
`define HIGH_RANGE_STEP_MV           16'h004B
`endif

// ### hdl/supply_monitor_pkg.sv
// types for the supply voltage monitor
package supply_monitor_pkg;
    typedef enum logic [1:0] {
        TRX_POWER_ON = 2'b00,
        TRX_SLEEP    = 2'b01,
        TRX_ACTIVE   = 2'b10
    } trx_state_type;

    typedef struct packed {
        logic       high_range_select;
        logic [3:0] threshold_code;
    } threshold_cfg_type;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_access_type;
endpackage : supply_monitor_pkg

// ### hdl/level_sync.sv
// two-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
module level_sync (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_nxt;

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r   <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end
endmodule : level_sync

// ### verification/tb.sv
// self-checking bench for the supply voltage monitor
`timescale 1ns/100ps
module tb;
    import supply_monitor_pkg::*;
    logic              sys_clk;
    logic              rst_b;
    logic              comparator_above;
    trx_state_type     transceiver_state_field;
    logic              synth_lock_flag;
    reg_access_type    reg_access;
    threshold_cfg_type threshold_cfg;
    logic              comparator_enable;
    logic [15:0]       threshold_mv;
    logic [7:0]        reg_rdata;
    logic              supply_low_interrupt;
    int                miscompares = 0;
    int                n_tests = 0;
    int                irq_cnt = 0;

    supply_monitor supply_monitor_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .comparator_above(comparator_above),
        .transceiver_state_field(transceiver_state_field),
        .synth_lock_flag(synth_lock_flag), .reg_access(reg_access),
        .threshold_cfg(threshold_cfg), .comparator_enable(comparator_enable),
        .threshold_mv(threshold_mv), .reg_rdata(reg_rdata),
        .supply_low_interrupt(supply_low_interrupt));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // counted on every edge so a stray pulse between checks is still seen
    always @(posedge sys_clk) begin
        if (supply_low_interrupt === 1'b1) begin
            irq_cnt++;
        end
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task end_of_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task access(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_access <= '{wr_en: w, rd_en: ~w, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_access <= '0;
        #1;
    endtask : access

    task rdchk(input logic [5:0] a, input logic [7:0] exp);
        access(1'b0, a, 8'h00);
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rdchk

    task wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc

    task setc(input logic v);
        @(posedge sys_clk);
        comparator_above <= v;
    endtask : setc

    initial begin
        #20000;
        miscompares++;
        end_of_test();
    end

    initial begin
        rst_b                   = 1'b0;
        comparator_above        = 1'b0;
        transceiver_state_field = TRX_POWER_ON;
        synth_lock_flag         = 1'b0;
        reg_access              = '0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        wait_cyc(1);
        chk(threshold_mv, 16'h0708);
        rdchk(6'h11, 8'h02);
        rdchk(6'h0E, 8'h00);
        access(1'b1, 6'h13, 8'hFF);
        rdchk(6'h13, 8'h00);
        @(posedge sys_clk);
        synth_lock_flag <= 1'b1;
        access(1'b1, 6'h11, 8'hFF);
        rdchk(6'h11, 8'hDF);
        @(posedge sys_clk);
        synth_lock_flag <= 1'b0;
        // whole threshold table, both ranges
        for (int h = 0; h < 2; h++) begin
            for (int c = 0; c < 16; c++) begin
                access(1'b1, 6'h11, 8'(h * 16 + c));
                chk(threshold_mv, h ? 16'(16'h09F6 + 16'h004B * c)
                                    : 16'(16'h06A4 + 16'h0032 * c));
                chk({11'h000, threshold_cfg}, 16'(h * 16 + c));
            end
        end
        access(1'b1, 6'h0E, 8'h80);
        access(1'b1, 6'h11, 8'h02);
        @(posedge sys_clk);
        transceiver_state_field <= TRX_ACTIVE;
        wait_cyc(8);
        chk(16'(irq_cnt), 16'h0000);
        chk({15'h0000, comparator_enable}, 16'h0001);
        access(1'b1, 6'h11, 8'h05);
        wait_cyc(8);
        chk(16'(irq_cnt), 16'h0000);
        setc(1'b1);
        wait_cyc(3);
        rdchk(6'h11, 8'h25);
        setc(1'b0);
        wait_cyc(2);
        chk({15'h0000, supply_low_interrupt}, 16'h0000);
        wait_cyc(1);
        chk({15'h0000, supply_low_interrupt}, 16'h0001);
        wait_cyc(1);
        chk({15'h0000, supply_low_interrupt}, 16'h0000);
        rdchk(6'h11, 8'h05);
        setc(1'b1);
        wait_cyc(4);
        access(1'b1, 6'h0E, 8'h00);
        setc(1'b0);
        wait_cyc(6);
        chk(16'(irq_cnt), 16'h0001);
        access(1'b1, 6'h0E, 8'h80);
        // neither idle state, nor the unused code, may report a falling supply
        for (int s = 0; s < 3; s++) begin
            setc(1'b1);
            wait_cyc(4);
            @(posedge sys_clk);
            transceiver_state_field <= trx_state_type'(2'((s == 2) ? 3 : s));
            setc(1'b0);
            wait_cyc(6);
            chk({15'h0000, comparator_enable}, 16'h0000);
            chk(16'(irq_cnt), 16'h0001);
            setc(1'b1);
            @(posedge sys_clk);
            transceiver_state_field <= TRX_ACTIVE;
        end
        wait_cyc(4);
        end_of_test();
    end
endmodule : tb
